// File: logic/synth_ctrl_pkg.sv
// Package with register map, field layout, reset values and timing counts
package synth_ctrl_pkg;
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 8;
  localparam int          TRIM_W           = 7;
  localparam int          STL_W            = 3;
  localparam int          MODE_W           = 2;
  localparam int          SETTLE_CNT_W     = 8;
  // Register byte addresses
  localparam logic [7:0]  ADDR_OVERRIDE    = 8'h58;
  localparam logic [7:0]  ADDR_OSC_TRIM    = 8'h59;
  localparam logic [7:0]  ADDR_SYNTH_HOLD  = 8'h5C;
  localparam logic [7:0]  ADDR_CAL_CTRL    = 8'h5D;
  localparam logic [7:0]  ADDR_CAL_STATUS  = 8'h5E;
  // Override register fields
  localparam int          OVR_SEL_BIT      = 7;
  localparam int          OVR_D_LSB        = 4;
  localparam int          OVR_C_LSB        = 2;
  localparam int          OVR_SE_BIT       = 1;
  localparam int          OVR_EN_BIT       = 0;
  // Calibration control, hold and status fields
  localparam int          CAL_STL_LSB      = 4;
  localparam int          CAL_EN_BIT       = 0;
  localparam int          HOLD_BIT         = 0;
  localparam int          DONE_BIT         = 0;
  // Reset values
  localparam logic [7:0]  RST_OVERRIDE     = 8'h00;
  localparam logic [6:0]  RST_OSC_TRIM     = 7'h00;
  localparam logic [7:0]  RST_SYNTH_HOLD   = 8'h00;
  localparam logic [2:0]  RST_CAL_STL      = 3'h4;
  localparam logic [7:0]  RST_CAL_CTRL     = 8'h40;
  // Divided-reference output codes
  localparam logic [1:0]  MODE_OFF         = 2'h0;
  localparam logic [1:0]  MODE_DIV1        = 2'h1;
  localparam logic [1:0]  MODE_DIV2        = 2'h2;
  localparam logic [1:0]  MODE_DIV4        = 2'h3;
  // Settling time per step of the settle field
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          SETTLE_UNIT_NS   = 1000;
  localparam int          SETTLE_UNIT_CYC  =
    (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0]  TRIM_MID         = 7'h40;
  localparam logic [2:0]  TRIM_TOP_BIT     = 3'h6;
endpackage : synth_ctrl_pkg

// File: logic/cal_link_if.sv
// Interface between register control and oscillator calibration engine
`timescale 1ns/1ns
interface cal_link_if;
  logic       calEnable;
  logic       hold;
  logic [2:0] settleSel;
  logic       oscFast;
  logic       trimLoad;
  logic [6:0] trimValue;
  logic       done;
  logic       busy;
  modport engine (input calEnable, hold, settleSel, oscFast,
                  output trimLoad, trimValue, done, busy);
  modport ctrl   (output calEnable, hold, settleSel, oscFast,
                  input trimLoad, trimValue, done, busy);
endinterface : cal_link_if

// File: logic/osc_cal_engine.sv
// Binary-search oscillator trim calibration engine
`timescale 1ns/1ns
module osc_cal_engine
  import synth_ctrl_pkg::*;
#(
  parameter int UNIT_CYC = SETTLE_UNIT_CYC
) (
  // Clock and control
  input wire logic   ref_clk,
  input wire logic   nrst,
  input wire logic   ce,
  // Link to control
  cal_link_if.engine lnk
);
  typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_DONE} cal_state_t;

  cal_state_t              state_q;
  logic                    holdPrev_q;
  logic [TRIM_W-1:0]       trial_q;
  logic [2:0]              bitIdx_q;
  logic [SETTLE_CNT_W-1:0] cnt_q;
  logic                    load_q;

  wire logic                    holdFall   = holdPrev_q & ~lnk.hold;
  // Monotonic settle count: (field + 1) units
  wire logic [SETTLE_CNT_W-1:0] settleCnt  =
    SETTLE_CNT_W'((32'(lnk.settleSel) + 32'd1) * UNIT_CYC);
  wire logic [TRIM_W-1:0]       bitMask    = TRIM_W'(7'h01 << bitIdx_q);
  wire logic [TRIM_W-1:0]       nextMask   = TRIM_W'(bitMask >> 1);
  wire logic [TRIM_W-1:0]       decided    =
    lnk.oscFast ? (trial_q & ~bitMask) : trial_q;
  wire logic                    lastBit    = (bitIdx_q == 3'h0);

  assign lnk.trimLoad  = load_q;
  assign lnk.trimValue = trial_q;
  assign lnk.busy      = (state_q == S_SETTLE);
  assign lnk.done      = (state_q == S_DONE);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q    <= S_IDLE;
      holdPrev_q <= 1'b0;
      trial_q    <= RST_OSC_TRIM;
      bitIdx_q   <= TRIM_TOP_BIT;
      cnt_q      <= '0;
      load_q     <= 1'b0;
    end else if (ce) begin
      holdPrev_q <= lnk.hold;
      load_q     <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (!lnk.hold && !lnk.calEnable) begin
            state_q <= S_DONE;
          end else if (holdFall && lnk.calEnable) begin
            state_q  <= S_SETTLE;
            trial_q  <= TRIM_MID;
            bitIdx_q <= TRIM_TOP_BIT;
            cnt_q    <= settleCnt;
            load_q   <= 1'b1;
          end
        end
        S_SETTLE: begin
          if (lnk.hold) begin
            state_q <= S_IDLE;
          end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - SETTLE_CNT_W'(1);
          end else if (lastBit) begin
            trial_q <= decided;
            load_q  <= 1'b1;
            state_q <= S_DONE;
          end else begin
            trial_q  <= decided | nextMask;
            bitIdx_q <= bitIdx_q - 3'h1;
            cnt_q    <= settleCnt;
            load_q   <= 1'b1;
          end
        end
        S_DONE: begin
          if (lnk.hold) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule : osc_cal_engine

// File: logic/synth_override_and_osc_cal_ctrl.sv
// Synthesizer pin override, oscillator trim and calibration register control
`timescale 1ns/1ns
module synth_override_and_osc_cal_ctrl
  import synth_ctrl_pkg::*;
#(
  parameter int UNIT_CYC = SETTLE_UNIT_CYC
) (
  // Clock, reset, enable
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Register access port from the serial interface
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [DATA_W-1:0] regRdata,
  // Configuration pins
  input  wire logic              synthEnablePin,
  input  wire logic              seRefclkPin,
  input  wire logic              clockConfigPin0,
  input  wire logic              clockConfigPin1,
  // Oscillator comparator from the analog side
  input  wire logic              oscFast,
  // Synthesizer controls
  output logic                   synthEnable,
  output logic                   seRefclkSelect,
  output logic      [MODE_W-1:0] refOutCSelect,
  output logic      [MODE_W-1:0] refOutDSelect,
  output logic                   synthConfigHold,
  output logic      [TRIM_W-1:0] oscTrim,
  output logic                   calDone,
  output logic                   calBusy
);
  logic [DATA_W-1:0] override_q;
  logic [TRIM_W-1:0] trim_q;
  logic              hold_q;
  logic [STL_W-1:0]  settle_q;
  logic              calEn_q;
  logic [DATA_W-1:0] rdata_q;
  logic              synthEn_q;
  logic              seSel_q;
  logic [MODE_W-1:0] modeC_q;
  logic [MODE_W-1:0] modeD_q;
  logic              done_q;
  logic              busy_q;

  cal_link_if lnk ();

  osc_cal_engine #(
    .UNIT_CYC (UNIT_CYC)
  ) u_engine (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ce      (ce),
    .lnk     (lnk)
  );

  assign lnk.calEnable = calEn_q;
  assign lnk.hold      = hold_q;
  assign lnk.settleSel = settle_q;
  assign lnk.oscFast   = oscFast;

  // Address decode
  wire logic wrOvr    = regWrite && (regAddr == ADDR_OVERRIDE);
  wire logic wrTrim   = regWrite && (regAddr == ADDR_OSC_TRIM);
  wire logic wrHold   = regWrite && (regAddr == ADDR_SYNTH_HOLD);
  wire logic wrCalCtl = regWrite && (regAddr == ADDR_CAL_CTRL);

  // Override field extraction
  wire logic              ovrOn   = override_q[OVR_SEL_BIT];
  wire logic [MODE_W-1:0] ovrD    = override_q[OVR_D_LSB +: MODE_W];
  wire logic [MODE_W-1:0] ovrC    = override_q[OVR_C_LSB +: MODE_W];
  wire logic [1:0]        cfgPins = {clockConfigPin1, clockConfigPin0};

  // Pin-mode output functions from the two config pins
  wire logic [MODE_W-1:0] pinC =
    (cfgPins == 2'h0) ? MODE_OFF  :
    (cfgPins == 2'h3) ? MODE_DIV2 : MODE_DIV1;
  wire logic [MODE_W-1:0] pinD =
    (cfgPins == 2'h2) ? MODE_DIV1 :
    (cfgPins == 2'h3) ? MODE_DIV2 : MODE_OFF;

  wire logic [MODE_W-1:0] selC  = ovrOn ? ovrC : pinC;
  wire logic [MODE_W-1:0] selDr = ovrOn ? ovrD : pinD;
  wire logic [MODE_W-1:0] selD  = (selC == MODE_OFF) ? MODE_OFF : selDr;
  wire logic selEn = ovrOn ? override_q[OVR_EN_BIT] : synthEnablePin;
  wire logic selSe = ovrOn ? override_q[OVR_SE_BIT] : seRefclkPin;

  // Read mux; reserved bits and unmapped addresses read zero
  wire logic [DATA_W-1:0] rdMux =
    (regAddr == ADDR_OVERRIDE)   ? override_q :
    (regAddr == ADDR_OSC_TRIM)   ? {1'b0, trim_q} :
    (regAddr == ADDR_SYNTH_HOLD) ? {7'h00, hold_q} :
    (regAddr == ADDR_CAL_CTRL)   ? {1'b0, settle_q, 3'h0, calEn_q} :
    (regAddr == ADDR_CAL_STATUS) ? {7'h00, lnk.done} : 8'h00;

  // Override register; reserved bit 6 kept at zero
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      override_q <= RST_OVERRIDE;
    end else if (ce && wrOvr) begin
      override_q <= regWdata & 8'hBF;
    end
  end

  // Trim: engine update has priority over host write while searching
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      trim_q <= RST_OSC_TRIM;
    end else if (ce && lnk.trimLoad) begin
      trim_q <= lnk.trimValue;
    end else if (ce && wrTrim) begin
      trim_q <= regWdata[TRIM_W-1:0];
    end
  end

  // Hold bit and calibration control
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      hold_q   <= RST_SYNTH_HOLD[HOLD_BIT];
      settle_q <= RST_CAL_CTRL[CAL_STL_LSB +: STL_W];
      calEn_q  <= RST_CAL_CTRL[CAL_EN_BIT];
    end else if (ce) begin
      if (wrHold) begin
        hold_q <= regWdata[HOLD_BIT];
      end
      if (wrCalCtl) begin
        settle_q <= regWdata[CAL_STL_LSB +: STL_W];
        calEn_q  <= regWdata[CAL_EN_BIT];
      end
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_q   <= 8'h00;
      synthEn_q <= 1'b0;
      seSel_q   <= 1'b0;
      modeC_q   <= MODE_OFF;
      modeD_q   <= MODE_OFF;
      done_q    <= 1'b0;
      busy_q    <= 1'b0;
    end else if (ce) begin
      if (regRead) begin
        rdata_q <= rdMux;
      end
      synthEn_q <= selEn;
      seSel_q   <= selSe;
      modeC_q   <= selC;
      modeD_q   <= selD;
      done_q    <= lnk.done;
      busy_q    <= lnk.busy;
    end
  end

  assign regRdata        = rdata_q;
  assign synthEnable     = synthEn_q;
  assign seRefclkSelect  = seSel_q;
  assign refOutCSelect   = modeC_q;
  assign refOutDSelect   = modeD_q;
  assign synthConfigHold = hold_q;
  assign oscTrim         = trim_q;
  assign calDone         = done_q;
  assign calBusy         = busy_q;
endmodule : synth_override_and_osc_cal_ctrl

// File: testbench/synth_ctrl_assertions.sv
// Port-level checker for override, trim and calibration control
`timescale 1ns/1ns
module synth_ctrl_checker
  import synth_ctrl_pkg::*;
#(
  parameter int UNIT_CYC = SETTLE_UNIT_CYC
) (
  // Clock, reset and register writes
  input wire logic              ref_clk, nrst, regWrite,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  // Pins and synthesizer controls
  input wire logic              synthEnablePin, seRefclkPin, clockConfigPin0, clockConfigPin1,
  input wire logic              synthEnable, seRefclkSelect, synthConfigHold, calDone, calBusy,
  input wire logic [MODE_W-1:0] refOutCSelect, refOutDSelect,
  input wire logic [TRIM_W-1:0] oscTrim
);
  // Longest search: seven steps of the largest settle count, plus pipeline
  localparam int SEARCH_MAX = 7 * (8 * UNIT_CYC + 1) + 2;
  logic [7:0] ovrQ;
  logic       calEnQ;
  logic       liveQ;
  wire  [1:0] cfg    = {clockConfigPin1, clockConfigPin0};
  wire  [3:0] pinMap = cfg == 2'h0 ? 4'h0 : cfg == 2'h1 ? 4'h4 : cfg == 2'h2 ? 4'h5 : 4'hA;
  // Mirror of the override and calibration enable bits
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ovrQ   <= 8'h00;
      calEnQ <= 1'b0;
      liveQ  <= 1'b0;
    end else if (ce) begin
      liveQ <= 1'b1;
      if (regWrite && regAddr == ADDR_OVERRIDE) ovrQ <= regWdata;
      if (regWrite && regAddr == ADDR_CAL_CTRL) calEnQ <= regWdata[CAL_EN_BIT];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst || !ce);
  a_ovr_enable: assert property (liveQ |->
    synthEnable == $past(ovrQ[7] ? ovrQ[0] : synthEnablePin)) else $error("enable source");
  a_ovr_seref: assert property (liveQ |->
    seRefclkSelect == $past(ovrQ[7] ? ovrQ[1] : seRefclkPin)) else $error("ref source");
  a_ovr_c_sel: assert property (liveQ && $past(ovrQ[7]) |->
    refOutCSelect == $past(ovrQ[3:2])) else $error("C select");
  a_ovr_d_sel: assert property (liveQ && $past(ovrQ[7]) && $past(ovrQ[3:2]) != 2'h0 |->
    refOutDSelect == $past(ovrQ[5:4])) else $error("D select");
  a_pin_mode_out: assert property (liveQ && !$past(ovrQ[7]) |->
    {refOutCSelect, refOutDSelect} == $past(pinMap)) else $error("pin mode outputs");
  a_d_needs_c: assert property (refOutDSelect != MODE_OFF |->
    refOutCSelect != MODE_OFF) else $error("D without C");
  a_hold_clears_done: assert property (synthConfigHold [*4] |-> !calDone)
    else $error("done under hold");
  a_skip_done: assert property ($fell(synthConfigHold) && !calEnQ |-> ##[1:4] calDone)
    else $error("skip not done");
  a_cal_starts: assert property ($fell(synthConfigHold) && calEnQ |-> ##[1:4] calBusy)
    else $error("search not started");
  a_cal_bounded: assert property ($rose(calBusy) |-> ##[1:SEARCH_MAX] !calBusy)
    else $error("search too long");
  a_trim_write: assert property (regWrite && regAddr == ADDR_OSC_TRIM && calDone |=>
    oscTrim == $past(regWdata[TRIM_W-1:0])) else $error("trim write lost");
endmodule : synth_ctrl_checker

bind synth_override_and_osc_cal_ctrl synth_ctrl_checker #(.UNIT_CYC(UNIT_CYC)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .regWrite(regWrite), .ce(ce),
  .regAddr(regAddr), .regWdata(regWdata),
  .synthEnablePin(synthEnablePin), .seRefclkPin(seRefclkPin), .clockConfigPin0(clockConfigPin0),
  .clockConfigPin1(clockConfigPin1), .synthEnable(synthEnable), .seRefclkSelect(seRefclkSelect),
  .synthConfigHold(synthConfigHold), .calDone(calDone), .calBusy(calBusy),
  .refOutCSelect(refOutCSelect), .refOutDSelect(refOutDSelect), .oscTrim(oscTrim));

// File: testbench/osc_model.sv
// Oscillator stand-in comparing trim with a fixed target
`timescale 1ns/1ns
module osc_model #(
  parameter logic [6:0] TARGET = 7'h2B
) (
  // Trim in, comparator out
  input  wire logic [6:0] trim,
  output logic            fast
);
  assign fast = trim > TARGET;
endmodule : osc_model

// File: testbench/synth_override_and_osc_cal_ctrl_tb_top.sv
// Self-checking bench for the synthesizer override and trim control
`timescale 1ns/1ns
module synth_override_and_osc_cal_ctrl_tb_top;
  import synth_ctrl_pkg::*;
  localparam int         U   = 1;
  localparam logic [6:0] TGT = 7'h2B;
  logic       ref_clk, nrst, ce, regWrite, regRead, oscFast, synthEnable, seRefclkSelect;
  logic       enPin, sePin, cfg0, cfg1, synthConfigHold, calDone, calBusy;
  logic [7:0] regAddr, regWdata, regRdata, e;
  logic [1:0] refOutCSelect, refOutDSelect, c, d, p;
  logic [6:0] oscTrim;
  logic [7:0] mdl [int];
  logic [31:0] rnd;
  int         mismatches = 0, comparisons = 0, cycles = 0, n, prev, st;
  synth_override_and_osc_cal_ctrl #(.UNIT_CYC(U)) u_dut (.ref_clk(ref_clk), .nrst(nrst),
    .ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .synthEnablePin(enPin), .seRefclkPin(sePin), .clockConfigPin0(cfg0),
    .clockConfigPin1(cfg1), .oscFast(oscFast), .synthEnable(synthEnable),
    .seRefclkSelect(seRefclkSelect), .refOutCSelect(refOutCSelect),
    .refOutDSelect(refOutDSelect), .synthConfigHold(synthConfigHold), .oscTrim(oscTrim),
    .calDone(calDone), .calBusy(calBusy));
  osc_model #(.TARGET(TGT)) u_osc (.trim(oscTrim), .fast(oscFast));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      ADDR_OVERRIDE:   return 8'hBF;
      ADDR_OSC_TRIM:   return 8'h7F;
      ADDR_SYNTH_HOLD: return 8'h01;
      ADDR_CAL_CTRL:   return 8'h71;
      default:         return 8'h00;
    endcase
  endfunction : msk
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= msk(a) != 8'h00 ? v & msk(a) : v;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    mdl[a] = (mdl[a] & ~msk(a)) | (v & msk(a));
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    chk(regRdata, mdl[a]);
  endtask : rd
  task automatic cal(input int s, input int stop);
    wr(ADDR_SYNTH_HOLD, 8'h01);
    wr(ADDR_CAL_CTRL, {1'b0, 3'(s), 4'h1});
    wr(ADDR_SYNTH_HOLD, 8'h00);
    n = 0;
    while (calDone !== 1'b1 && n < stop) begin
      @(negedge ref_clk);
      n++;
    end
    chk({7'h00, synthConfigHold}, 8'h00);
  endtask : cal
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    {nrst, regWrite, regRead, enPin, sePin, cfg0, cfg1} = '0;
    {regAddr, regWdata} = '0;
    ce = 1'b1;
    rnd = 32'hC1838D3A;
    prev = 0;
    for (int a = 8'h58; a <= 8'h5E; a++) mdl[a] = 8'h00;
    mdl[ADDR_CAL_CTRL] = RST_CAL_CTRL;
    mdl[ADDR_CAL_STATUS] = 8'h01;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int a = 8'h58; a <= 8'h5E; a++) rd(8'(a));
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      @(posedge ref_clk);
      {enPin, sePin, cfg0, cfg1} <= rnd[11:8];
      wr(ADDR_OVERRIDE, rnd[7:0]);
      wr(ADDR_OSC_TRIM, rnd[23:16]);
      wr(i[0] ? ADDR_CAL_STATUS : 8'h5A, rnd[31:24]);
      rd(ADDR_OVERRIDE);
      rd(ADDR_OSC_TRIM);
      rd(i[0] ? ADDR_CAL_STATUS : 8'h5A);
      e = mdl[ADDR_OVERRIDE];
      p = {cfg1, cfg0};
      c = e[7] ? e[3:2] : (p == 2'h3 ? 2'h2 : p != 2'h0 ? 2'h1 : 2'h0);
      d = e[7] ? (c == 2'h0 ? 2'h0 : e[5:4]) : (p == 2'h3 ? 2'h2 : p == 2'h2 ? 2'h1 : 2'h0);
      chk({2'b0, synthEnable, seRefclkSelect, refOutCSelect, refOutDSelect},
          {2'b0, e[7] ? e[0] : enPin, e[7] ? e[1] : sePin, c, d});
    end
    // Clock enable low: a write must not land
    @(posedge ref_clk);
    ce <= 1'b0;
    e = mdl[ADDR_OVERRIDE];
    wr(ADDR_OVERRIDE, ~e);
    mdl[ADDR_OVERRIDE] = e;
    ce <= 1'b1;
    rd(ADDR_OVERRIDE);
    for (int k = 0; k < 3; k++) begin
      st = k == 0 ? 0 : k == 1 ? 4 : 7;
      cal(st, 500);
      chk({1'b0, oscTrim}, {1'b0, TGT});
      chk(8'(n > prev), 8'h01);
      chk(8'(n >= 7 * ((st + 1) * U + 1) && n <= 7 * ((st + 1) * U + 1) + 8), 8'h01);
      prev = n;
      mdl[ADDR_OSC_TRIM] = {1'b0, TGT};
      rd(ADDR_OSC_TRIM);
      rd(ADDR_CAL_CTRL);
    end
    cal(7, 10);
    chk(8'(calBusy), 8'h01);
    wr(ADDR_SYNTH_HOLD, 8'h01);
    repeat (6) @(posedge ref_clk);
    mdl[ADDR_CAL_STATUS] = 8'h00;
    rd(ADDR_CAL_STATUS);
    wr(ADDR_CAL_CTRL, 8'h40);
    wr(ADDR_SYNTH_HOLD, 8'h00);
    repeat (4) @(posedge ref_clk);
    mdl[ADDR_CAL_STATUS] = 8'h01;
    rd(ADDR_CAL_STATUS);
    wrap_up();
  end
endmodule : synth_override_and_osc_cal_ctrl_tb_top
